// >>> shared/lca_pkg.sv
/*
 * Package for the logic and compare unit: operation codes, register map,
 * flag positions and bus constants.
 * Assumes an AHB-Lite slave with 32-bit data and one clock.
 */
package lca_pkg;

	localparam int DW = 8;

	// ************************************************************
	// Operation codes
	// ************************************************************
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_AND = 4'b0001,
		OP_OR = 4'b0010,
		OP_XOR = 4'b0011,
		OP_XOR_PORT = 4'b0100,
		OP_NOT = 4'b0101,
		OP_NEG = 4'b0110,
		OP_CMP_WM = 4'b0111,
		OP_CMP_MW = 4'b1000
	} lca_op_t;

	// Source: immediate or memory; destination: work register or memory
	localparam logic SRC_IMM = 1'b0;
	localparam logic SRC_MEM = 1'b1;
	localparam logic DST_WORK = 1'b0;
	localparam logic DST_MEM = 1'b1;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] REG_WORK = 8'h00;
	localparam logic [7:0] REG_FLAGS = 8'h04;
	localparam logic [7:0] REG_PORT = 8'h08;
	localparam logic [7:0] REG_CMD = 8'h0c;
	localparam logic [7:0] REG_RESULT = 8'h10;

	localparam logic [7:0] MEM_BASE = 8'h40;
	localparam int MEM_AW = 4;

	// Flag bit positions
	localparam int FLG_Z = 0;
	localparam int FLG_C = 1;
	localparam int FLG_HC = 2;
	localparam int FLG_SW = 3;
	localparam int FLG_W = 4;

	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_SRC = 4;
	localparam int CMD_DST = 5;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_IMM_LSB = 16;

	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [7:0] PORT_RST = 8'h00;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	typedef struct packed {
		logic [7:0] value;
		logic [3:0] flags;
		logic wr_work;
		logic wr_mem;
		logic wr_port;
		logic wr_flags;
	} lca_res_t;

endpackage

// >>> rtl/lca_mem.sv
/*
 * Small data memory holding the operand bytes, one write port and one
 * registered read port.
 * Assumes a single clock; read data valid one cycle after the address.
 */
module lca_mem #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	input wire logic hclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule

// >>> rtl/lca_top.sv
/*
 * Logic and compare unit of an 8-bit core, with its work register, flags,
 * port latch and data memory reached over AHB-Lite.
 * Assumes a single AHB-Lite master, word transfers, clock hclk.
 */
// The AHB-Lite register port and the address map are this design's own decisions.
// How it works
// - AND of work register with immediate or memory, to register or memory
// - OR of work register with immediate or memory, to register or memory
// - XOR of work register with immediate or memory, to register or memory
// - XOR into port latch, all four flags unchanged
// - Logic, not and neg update only zero flag; others kept
// - Not inverts work register or memory byte in place
// - Neg replaces work register or memory byte with its negation
// - Compare work minus memory sets all flags, writes only the result register
// - Reversed compare memory minus work sets all flags, writes only the result register
// - Equal operands in a compare set the zero flag
// - Work register smaller than memory sets carry as borrow in compare work minus memory
module lca_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [7:0] work_register,
	output logic [7:0] port_a_latch,
	output logic [3:0] flags
);

	// ************************************************************
	// Arithmetic helpers
	// ************************************************************
	// Subtract a - b; returns {result, flags} with flags at their bit places
	function automatic logic [11:0] sub8(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		logic [7:0] r;
		logic c;
		logic hc;
		logic sw;
		logic [3:0] f;
		full = {1'b0, a} - {1'b0, b};
		low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		r = full[7:0];
		c = full[8];
		hc = low[4];
		sw = (a[7] ^ b[7]) & (a[7] ^ r[7]);
		f[lca_pkg::FLG_Z] = (r == 8'h00);
		f[lca_pkg::FLG_C] = c;
		f[lca_pkg::FLG_HC] = hc;
		f[lca_pkg::FLG_SW] = sw;
		sub8 = {r, f};
	endfunction

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction

	// ************************************************************
	// Bus state
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b10,
		ST_EXEC = 2'b11
	} lca_st_t;

	lca_st_t st_r, st_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [7:0] work_r, work_nxt;
	logic [7:0] port_r, port_nxt;
	logic [3:0] flags_r, flags_nxt;
	logic [7:0] result_r, result_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic rdy_r, rdy_nxt;
	logic [31:0] cmd_r, cmd_nxt;

	logic mem_we;
	logic [lca_pkg::MEM_AW-1:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [lca_pkg::MEM_AW-1:0] mem_raddr;
	logic [7:0] mem_rdata;

	logic take;
	logic is_mem;

	assign take = hsel & hready & (htrans == lca_pkg::HTRANS_NONSEQ);
	// Nine bits so that the window end past 0xff does not wrap to zero
	assign is_mem = ({1'b0, addr_r} >= {1'b0, lca_pkg::MEM_BASE}) &&
		({1'b0, addr_r} < {1'b0, lca_pkg::MEM_BASE} +
		9'(4 << lca_pkg::MEM_AW));

	lca_mem #(
		.AW(lca_pkg::MEM_AW),
		.DW(lca_pkg::DW)
	) u_mem (
		.hclk(hclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// ************************************************************
	// Execution datapath
	// ************************************************************
	lca_pkg::lca_op_t op;
	logic [7:0] opnd;
	logic [11:0] sub_wm;
	logic [11:0] sub_mw;
	lca_pkg::lca_res_t res;

	assign op = lca_pkg::lca_op_t'(cmd_r[lca_pkg::CMD_OP_LSB +: 4]);
	assign opnd = (cmd_r[lca_pkg::CMD_SRC] == lca_pkg::SRC_MEM) ?
		mem_rdata : cmd_r[lca_pkg::CMD_IMM_LSB +: 8];
	assign sub_wm = sub8(work_r, mem_rdata);
	assign sub_mw = sub8(mem_rdata, work_r);

	always_comb begin
		logic dmem;
		logic [7:0] src;
		dmem = cmd_r[lca_pkg::CMD_DST] == lca_pkg::DST_MEM;
		src = dmem ? mem_rdata : work_r;
		res = '0;
		res.flags = flags_r;
		case (op)
			lca_pkg::OP_AND, lca_pkg::OP_OR, lca_pkg::OP_XOR: begin
				if (op == lca_pkg::OP_AND) begin
					res.value = work_r & (dmem ? mem_rdata : opnd);
				end else if (op == lca_pkg::OP_OR) begin
					res.value = work_r | (dmem ? mem_rdata : opnd);
				end else begin
					res.value = work_r ^ (dmem ? mem_rdata : opnd);
				end
				res.wr_work = !dmem;
				res.wr_mem = dmem;
				res.flags[lca_pkg::FLG_Z] = is_zero(res.value);
			end
			lca_pkg::OP_XOR_PORT: begin
				res.value = work_r ^ port_r;
				res.wr_port = 1'b1;
			end
			lca_pkg::OP_NOT: begin
				res.value = ~src;
				res.wr_work = !dmem;
				res.wr_mem = dmem;
				res.flags[lca_pkg::FLG_Z] = is_zero(res.value);
			end
			lca_pkg::OP_NEG: begin
				res.value = 8'(~src + 8'h01);
				res.wr_work = !dmem;
				res.wr_mem = dmem;
				res.flags[lca_pkg::FLG_Z] = is_zero(res.value);
			end
			lca_pkg::OP_CMP_WM: begin
				res.value = sub_wm[11:4];
				res.flags = sub_wm[3:0];
			end
			lca_pkg::OP_CMP_MW: begin
				res.value = sub_mw[11:4];
				res.flags = sub_mw[3:0];
			end
			default: begin
				res.value = result_r;
			end
		endcase
	end

	// ************************************************************
	// Bus and register next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		addr_nxt = addr_r;
		work_nxt = work_r;
		port_nxt = port_r;
		flags_nxt = flags_r;
		result_nxt = result_r;
		hrdata_nxt = hrdata_r;
		rdy_nxt = 1'b1;
		cmd_nxt = cmd_r;
		mem_we = 1'b0;
		mem_waddr = addr_r[2 +: lca_pkg::MEM_AW];
		mem_wdata = hwdata[7:0];
		mem_raddr = haddr[2 +: lca_pkg::MEM_AW];
		case (st_r)
			ST_IDLE: begin
				if (take) begin
					addr_nxt = haddr;
					st_nxt = hwrite ? ST_WRITE : ST_READ;
					rdy_nxt = hwrite;
				end
			end
			ST_READ: begin
				hrdata_nxt = '0;
				if (is_mem) begin
					hrdata_nxt[7:0] = mem_rdata;
				end else begin
					case (addr_r)
						lca_pkg::REG_WORK: hrdata_nxt[7:0] = work_r;
						lca_pkg::REG_FLAGS: hrdata_nxt[3:0] = flags_r;
						lca_pkg::REG_PORT: hrdata_nxt[7:0] = port_r;
						lca_pkg::REG_CMD: hrdata_nxt = cmd_r;
						lca_pkg::REG_RESULT: hrdata_nxt[7:0] = result_r;
						default: hrdata_nxt = '0;
					endcase
				end
				st_nxt = ST_IDLE;
			end
			ST_WRITE: begin
				st_nxt = ST_IDLE;
				if (is_mem) begin
					mem_we = 1'b1;
				end else begin
					case (addr_r)
						lca_pkg::REG_WORK: work_nxt = hwdata[7:0];
						lca_pkg::REG_FLAGS: flags_nxt = hwdata[3:0];
						lca_pkg::REG_PORT: port_nxt = hwdata[7:0];
						lca_pkg::REG_CMD: begin
							cmd_nxt = hwdata;
							mem_raddr = hwdata[lca_pkg::CMD_ADDR_LSB +:
								lca_pkg::MEM_AW];
							st_nxt = ST_EXEC;
							rdy_nxt = 1'b0;
						end
						default: ;
					endcase
				end
			end
			ST_EXEC: begin
				// Memory operand read last cycle; commit the result
				if (res.wr_work) begin
					work_nxt = res.value;
				end
				if (res.wr_port) begin
					port_nxt = res.value;
				end
				if (res.wr_mem) begin
					mem_we = 1'b1;
					mem_waddr = cmd_r[lca_pkg::CMD_ADDR_LSB +:
						lca_pkg::MEM_AW];
					mem_wdata = res.value;
				end
				flags_nxt = res.flags;
				result_nxt = res.value;
				st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= ST_IDLE;
			addr_r <= 8'h00;
			work_r <= lca_pkg::WORK_RST;
			port_r <= lca_pkg::PORT_RST;
			flags_r <= lca_pkg::FLAGS_RST;
			result_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			rdy_r <= 1'b1;
			cmd_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			addr_r <= addr_nxt;
			work_r <= work_nxt;
			port_r <= port_nxt;
			flags_r <= flags_nxt;
			result_r <= result_nxt;
			hrdata_r <= hrdata_nxt;
			rdy_r <= rdy_nxt;
			cmd_r <= cmd_nxt;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = rdy_r;
	assign hresp = 1'b0;
	assign work_register = work_r;
	assign port_a_latch = port_r;
	assign flags = flags_r;

endmodule

// >>> sim/lca_host.sv
/*
 * Decoder side of the unit: issues single word transfers over AHB-Lite.
 * Assumes hready is the slave's hreadyout and one clock hclk.
 */
module lca_host (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [7:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Bus transfer
	// ****************
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= lca_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

// >>> sim/lca_props.sv
/*
 * Checker for the unit: results and flags three edges after a command.
 * Assumes a command commits within two edges of its data phase.
 */
module lca_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic [7:0] work_register,
	input wire logic [7:0] port_a_latch,
	input wire logic [3:0] flags
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Command capture
	// ****************
	logic ph_r, ck, dst, src;
	logic [1:0] cnt_r;
	logic [31:0] cmd_r;
	logic [7:0] w_r, p_r, imm;
	logic [3:0] f_r, op;
	assign ck = cnt_r == 2'h3;
	assign op = cmd_r[3:0];
	assign src = cmd_r[4];
	assign dst = cmd_r[5];
	assign imm = cmd_r[23:16];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (hready)
				ph_r <= hsel && htrans == lca_pkg::HTRANS_NONSEQ && hwrite
					&& haddr == lca_pkg::REG_CMD;
			if (ph_r && hready)
				cnt_r <= 2'h1;
			else if (cnt_r != 2'h0)
				cnt_r <= cnt_r + 2'h1;
		end
	end
	always_ff @(posedge hclk) begin
		if (ph_r && hready) begin
			cmd_r <= hwdata;
			w_r <= work_register;
			p_r <= port_a_latch;
			f_r <= flags;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_and_imm: assert property (ck && op == 4'h1 && !src && !dst |->
		work_register == (w_r & imm)) else $error("and result wrong");
	a_or_imm: assert property (ck && op == 4'h2 && !src && !dst |->
		work_register == (w_r | imm)) else $error("or result wrong");
	a_xor_imm: assert property (ck && op == 4'h3 && !src && !dst |->
		work_register == (w_r ^ imm)) else $error("xor result wrong");
	a_port_xor: assert property (ck && op == 4'h4 |->
		port_a_latch == (p_r ^ w_r) && flags == f_r) else $error("port xor");
	a_keep_flags: assert property (ck && op inside {[1:3], 5, 6} |->
		flags[3:1] == f_r[3:1]) else $error("flags changed");
	a_not_work: assert property (ck && op == 4'h5 && !dst |->
		work_register == ~w_r) else $error("not result wrong");
	a_neg_work: assert property (ck && op == 4'h6 && !dst |->
		work_register == 8'h00 - w_r) else $error("neg result wrong");
	a_zero_exact: assert property (ck && op inside {[1:3], 5, 6} && !dst |->
		flags[0] == (work_register == 8'h00)) else $error("zero flag");
	a_cmp_still: assert property (ck && op inside {7, 8} |->
		work_register == w_r && port_a_latch == p_r) else $error("cmp wrote");
	a_cmd_stall: assert property (ph_r && hready |=> !hreadyout ##1 hreadyout)
		else $error("no execute cycle");

	c_port: cover property (ck && op == 4'h4);
	c_cmp: cover property (ck && op == 4'h7);
	c_neg_mem: cover property (ck && op == 4'h6 && dst);
endmodule

bind lca_top lca_props lca_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hreadyout, .work_register, .port_a_latch,
	.flags);

// >>> sim/lca_top_bench.sv
/*
 * Self-checking bench of the logic and compare unit.
 * Assumes the host model drives the bus; memory byte 5 is the operand.
 */
module lca_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [7:0] haddr, work_register, port_a_latch;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	logic [3:0] flags;
	int n_fail = 0;
	int n_checks = 0;
	localparam logic [7:0] M5 = 8'h54;

	lca_top lca_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.work_register, .port_a_latch, .flags);
	lca_host lca_host_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);

	// ****************
	// Helpers
	// ****************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		lca_host_i.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		lca_host_i.xfer(1'b0, a, 32'h0, q);
		n_checks++;
		if (hresp !== 1'b0) begin
			n_fail++;
			$display("[ERR] %0t hresp %h exp %h", $time, hresp, 1'b0);
		end
		if (q !== {24'h0, e}) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, q, {24'h0, e});
		end
	endtask

	task automatic run(input logic [3:0] op, input logic s, input logic d);
		wr(lca_pkg::REG_CMD, {8'h00, 8'hc3, 8'h05, 2'b00, d, s, op});
	endtask

	task automatic set3(input logic [7:0] w, input logic [7:0] m,
		input logic [3:0] f);
		wr(lca_pkg::REG_WORK, {24'h0, w});
		wr(M5, {24'h0, m});
		wr(lca_pkg::REG_FLAGS, {28'h0, f});
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		rd(lca_pkg::REG_WORK, 8'h00);
		rd(lca_pkg::REG_FLAGS, 8'h00);
		rd(lca_pkg::REG_PORT, 8'h00);
		wr(8'h20, 32'h5a);
		rd(8'h20, 8'h00);
	endtask

	task automatic t_logic;
		logic [7:0] b, e;
		for (int k = 1; k < 4; k++) begin
			for (int j = 0; j < 3; j++) begin
				set3(8'h3c, 8'ha5, 4'he);
				run(k[3:0], j > 0, j > 1);
				b = j > 0 ? 8'ha5 : 8'hc3;
				e = k == 1 ? 8'h3c & b : k == 2 ? 8'h3c | b : 8'h3c ^ b;
				rd(j > 1 ? M5 : lca_pkg::REG_WORK, e);
				rd(lca_pkg::REG_FLAGS, {5'h07, e == 8'h00});
			end
		end
	endtask

	task automatic t_unary;
		logic [7:0] e;
		for (int k = 5; k < 7; k++) begin
			for (int d = 0; d < 2; d++) begin
				set3(8'h38, 8'h38, 4'he);
				run(k[3:0], 1'b0, d[0]);
				e = k == 5 ? 8'hc7 : 8'hc8;
				rd(d ? M5 : lca_pkg::REG_WORK, e);
				rd(lca_pkg::REG_FLAGS, 8'h0e);
			end
		end
	endtask

	task automatic t_port;
		set3(8'hff, 8'h00, 4'hf);
		wr(lca_pkg::REG_PORT, 32'h0f);
		run(4'h4, 1'b0, 1'b0);
		rd(lca_pkg::REG_PORT, 8'hf0);
		rd(lca_pkg::REG_FLAGS, 8'h0f);
	endtask

	task automatic t_cmp;
		logic [7:0] w[4] = '{8'h38, 8'h38, 8'h38, 8'h80};
		logic [7:0] m[4] = '{8'h38, 8'h42, 8'h42, 8'h01};
		logic [3:0] f[4] = '{4'h1, 4'h2, 4'h4, 4'hc};
		logic [7:0] r[4] = '{8'h00, 8'hf6, 8'h0a, 8'h7f};
		for (int i = 0; i < 4; i++) begin
			set3(w[i], m[i], ~f[i]);
			run(i == 2 ? 4'h8 : 4'h7, 1'b1, 1'b0);
			rd(lca_pkg::REG_FLAGS, {4'h0, f[i]});
			rd(lca_pkg::REG_WORK, w[i]);
			rd(M5, m[i]);
			rd(lca_pkg::REG_RESULT, r[i]);
		end
	endtask

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	initial begin
		#200000;
		n_fail++;
		end_sim();
	end

	initial begin
		hresetn = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_logic();
		t_unary();
		t_port();
		t_cmp();
		end_sim();
	end
endmodule
